// ==== common/serial_frame_defs.vh ====
// Register indices, field positions, reset values and codes for the serial frame unit
`ifndef SERIAL_FRAME_DEFS_VH
`define SERIAL_FRAME_DEFS_VH

// Register indices; byte address is four times the index
`define SFC_IDX_U0C0 20'hF0118
`define SFC_IDX_U0C3 20'hF011E
`define SFC_IDX_U1C0 20'hF0158
`define SFC_IDX_U1C1 20'hF015A
`define SFC_IDX_TXDATA 20'h00000
`define SFC_IDX_RXDATA 20'h00001
`define SFC_IDX_STATUS 20'h00002
`define SFC_IDX_MASK 20'h00003
`define SFC_IDX_BAUD 20'h00004
`define SFC_IDX_STATE 20'h00005

// Configuration register layout
`define SFC_CFG_RESET 16'h0087
`define SFC_CFG_WMASK 16'hF7B3
`define SFC_CFG_FIXED1 16'h0004
`define SFC_CFG_NO2STOP 16'hFFDF
`define SFC_TXE_BIT 15
`define SFC_RXE_BIT 14
`define SFC_EOC_BIT 10
`define SFC_PAR_HI 9
`define SFC_PAR_LO 8
`define SFC_DIR_BIT 7
`define SFC_STOP_HI 5
`define SFC_STOP_LO 4
`define SFC_LEN_HI 1
`define SFC_LEN_LO 0

// Field codes
`define SFC_PAR_NONE 2'h0
`define SFC_PAR_ZERO 2'h1
`define SFC_PAR_EVEN 2'h2
`define SFC_PAR_ODD 2'h3
`define SFC_STOP_NONE 2'h0
`define SFC_STOP_TWO 2'h2
`define SFC_LEN_9 2'h1
`define SFC_LEN_7 2'h2

// Interrupt flag positions
`define SFC_IRQ_TXEND 0
`define SFC_IRQ_RXEND 1
`define SFC_IRQ_RXERR 2
`define SFC_IRQ_OVR 3

// Reset values of own registers
`define SFC_BAUD_RESET 16'h043D
`define SFC_MASK_RESET 4'h0

`endif

// ==== design/serial_frame_tx.v ====
// Frame transmitter: start, data, optional parity, stop bits
`timescale 1ns/100ps
`include "serial_frame_defs.vh"
module serial_frame_tx #(
  parameter DIV_W = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [DIV_W-1:0] div_i,
  input wire start_i,
  input wire [8:0] data_i,
  input wire [1:0] parity_i,
  input wire lsb_first_i,
  input wire [1:0] stop_i,
  input wire [1:0] len_i,
  output reg txd_o,
  output reg busy_o,
  output reg done_o
);
  localparam IDLE = 3'd0;
  localparam START = 3'd1;
  localparam DATA = 3'd2;
  localparam PAR = 3'd3;
  localparam STOP = 3'd4;

  reg [2:0] state;
  reg [DIV_W-1:0] cnt;
  reg [3:0] idx;
  reg [8:0] sh;
  reg [1:0] par_q;
  reg lsb_q;
  reg [1:0] stop_q;
  reg [3:0] nbits;
  reg acc;
  wire [DIV_W-1:0] div_m1 = (div_i == {DIV_W{1'b0}}) ? {DIV_W{1'b0}} : div_i - 1'b1;
  wire tick = (cnt == {DIV_W{1'b0}});
  wire acc_n = acc ^ txd_o;
  wire [3:0] nstops = (stop_q == `SFC_STOP_TWO) ? 4'd2 : 4'd1;

  // Word length from the length code; the prohibited code falls back to eight
  function [3:0] word_bits;
    input [1:0] code;
    begin
      word_bits = (code == `SFC_LEN_9) ? 4'd9 : (code == `SFC_LEN_7) ? 4'd7 : 4'd8;
    end
  endfunction

  // Bit of the word sent in slot i
  function pick;
    input [8:0] d;
    input [3:0] i;
    input [3:0] n;
    input l;
    begin
      pick = l ? d[i] : d[n - 4'd1 - i];
    end
  endfunction

  // Bit timer and frame sequencer; configuration is frozen at the start bit
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= IDLE;
      cnt <= {DIV_W{1'b0}};
      idx <= 4'h0;
      sh <= 9'h000;
      par_q <= 2'h0;
      lsb_q <= 1'b0;
      stop_q <= 2'h0;
      nbits <= 4'h8;
      acc <= 1'b0;
      txd_o <= 1'b1;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (state != IDLE)
        cnt <= tick ? div_m1 : cnt - 1'b1;
      case (state)
        IDLE: begin
          txd_o <= 1'b1;
          if (start_i) begin
            sh <= data_i;
            par_q <= parity_i;
            lsb_q <= lsb_first_i;
            stop_q <= stop_i;
            nbits <= word_bits(len_i);
            cnt <= div_m1;
            txd_o <= 1'b0;
            busy_o <= 1'b1;
            state <= START;
          end
        end
        START: if (tick) begin
          idx <= 4'h0;
          acc <= 1'b0;
          txd_o <= pick(sh, 4'h0, nbits, lsb_q);
          state <= DATA;
        end
        DATA: if (tick) begin
          acc <= acc_n;
          if (idx == nbits - 4'd1) begin
            if (par_q != `SFC_PAR_NONE) begin
              state <= PAR;
              txd_o <= (par_q == `SFC_PAR_ZERO) ? 1'b0 : (par_q == `SFC_PAR_EVEN) ? acc_n : ~acc_n;
            end else if (stop_q == `SFC_STOP_NONE) begin
              state <= IDLE;
              txd_o <= 1'b1;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end else begin
              state <= STOP;
              idx <= 4'h0;
              txd_o <= 1'b1;
            end
          end else begin
            idx <= idx + 4'd1;
            txd_o <= pick(sh, idx + 4'd1, nbits, lsb_q);
          end
        end
        PAR: if (tick) begin
          idx <= 4'h0;
          txd_o <= 1'b1;
          if (stop_q == `SFC_STOP_NONE) begin
            state <= IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else
            state <= STOP;
        end
        STOP: if (tick) begin
          // End pulse only once the last stop bit has run its full time
          if (idx + 4'd1 == nstops) begin
            state <= IDLE;
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end else
            idx <= idx + 4'd1;
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule // serial_frame_tx

// ==== design/serial_frame_rx.v ====
// Frame receiver: mid-bit sampling, parity check and stop-bit check
`timescale 1ns/100ps
`include "serial_frame_defs.vh"
module serial_frame_rx #(
  parameter DIV_W = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [DIV_W-1:0] div_i,
  input wire enable_i,
  input wire rxd_i,
  input wire [1:0] parity_i,
  input wire lsb_first_i,
  input wire [1:0] stop_i,
  input wire [1:0] len_i,
  output reg [8:0] data_o,
  output reg done_o,
  output reg err_o
);
  localparam IDLE = 3'd0;
  localparam START = 3'd1;
  localparam DATA = 3'd2;
  localparam PAR = 3'd3;
  localparam STOP = 3'd4;

  reg [2:0] state;
  reg [DIV_W-1:0] cnt;
  reg [3:0] idx;
  reg [8:0] sh;
  reg [1:0] par_q;
  reg lsb_q;
  reg [1:0] stop_q;
  reg [3:0] nbits;
  reg acc;
  reg perr;
  reg ferr;
  reg fin;
  wire [DIV_W-1:0] div_m1 = (div_i == {DIV_W{1'b0}}) ? {DIV_W{1'b0}} : div_i - 1'b1;
  wire tick = (cnt == {DIV_W{1'b0}});
  wire [3:0] nstops = (stop_q == `SFC_STOP_TWO) ? 4'd2 : 4'd1;

  function [3:0] word_bits;
    input [1:0] code;
    begin
      word_bits = (code == `SFC_LEN_9) ? 4'd9 : (code == `SFC_LEN_7) ? 4'd7 : 4'd8;
    end
  endfunction

  // Sequencer; the word is published one cycle after the last sample so the final bit is in
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= IDLE;
      cnt <= {DIV_W{1'b0}};
      idx <= 4'h0;
      sh <= 9'h000;
      par_q <= 2'h0;
      lsb_q <= 1'b0;
      stop_q <= 2'h0;
      nbits <= 4'h8;
      acc <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
      fin <= 1'b0;
      data_o <= 9'h000;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      fin <= 1'b0;
      done_o <= fin;
      err_o <= fin & (perr | ferr);
      if (fin)
        data_o <= sh;
      if (state != IDLE)
        cnt <= tick ? div_m1 : cnt - 1'b1;
      case (state)
        IDLE: if (enable_i && !rxd_i) begin
          cnt <= {1'b0, div_m1[DIV_W-1:1]}; // Half a bit to reach mid start bit
          sh <= 9'h000;
          par_q <= parity_i;
          lsb_q <= lsb_first_i;
          stop_q <= stop_i;
          nbits <= word_bits(len_i);
          perr <= 1'b0;
          ferr <= 1'b0;
          acc <= 1'b0;
          idx <= 4'h0;
          state <= START;
        end
        START: if (tick)
          state <= rxd_i ? IDLE : DATA; // A short glitch is not a start bit
        DATA: if (tick) begin
          if (lsb_q)
            sh[idx] <= rxd_i;
          else
            sh[nbits - 4'd1 - idx] <= rxd_i;
          acc <= acc ^ rxd_i;
          idx <= idx + 4'd1;
          if (idx == nbits - 4'd1) begin
            idx <= 4'h0;
            if (par_q != `SFC_PAR_NONE)
              state <= PAR;
            else if (stop_q == `SFC_STOP_NONE) begin
              state <= IDLE;
              fin <= 1'b1;
            end else
              state <= STOP;
          end
        end
        PAR: if (tick) begin
          // Zero-parity code carries a bit that is not judged
          perr <= (par_q == `SFC_PAR_EVEN) ? (acc ^ rxd_i) :
                  (par_q == `SFC_PAR_ODD) ? ~(acc ^ rxd_i) : 1'b0;
          if (stop_q == `SFC_STOP_NONE) begin
            state <= IDLE;
            fin <= 1'b1;
          end else
            state <= STOP;
        end
        STOP: if (tick) begin
          ferr <= ferr | ~rxd_i;
          if (idx + 4'd1 == nstops) begin
            state <= IDLE;
            fin <= 1'b1;
          end else
            idx <= idx + 4'd1;
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule // serial_frame_rx

// ==== design/serial_frame_unit.v ====
// Serial frame unit: configuration registers, Avalon-MM slave, interrupt flags, UART channel
//
// What this block does
// - Configuration word is 16 bits, resets to 0x0087, holds enables, parity, order, stop, length.
// - Parity 00 sends and expects none; 01 sends zero parity, receiver ignores it.
// - Bit-order flag 0 shifts MSB first, 1 shifts LSB first.
// - Stop code 00 none, 01 one, 10 two stop bits; 11 prohibited.
// - Two stop bits exist only on channels 00 and 10.
// - Transfer-end interrupt fires only after every stop bit has been shifted out.
// - Length code 01 gives 9-bit words in data bits 0 to 8, UART only.
// - Length 10 gives 7-bit, 11 gives 8-bit words; code 00 prohibited.
// - Transmit-end, clocked and two-wire sources of channel 10 share request flag bit 0.
// - Receive-end, clocked and two-wire sources of channel 11 share request flag bit 1.
// - Receive-error (gated by error enable) and timer channel 3 upper interrupts share flag bit 2.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
`include "serial_frame_defs.vh"
module serial_frame_unit #(
  parameter ADDR_W = 22,
  parameter DIV_W = 16
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire rxd_i,
  output wire txd_o,
  input wire u1c0_sync_irq_i,
  input wire u1c0_twowire_irq_i,
  input wire u1c1_sync_irq_i,
  input wire u1c1_twowire_irq_i,
  input wire timer_ch3_upper_irq_i,
  output reg irq_o
);
  // Configuration words of the four channels
  reg [15:0] serial_frame_cfg_u0c0;
  reg [15:0] serial_frame_cfg_u0c3;
  reg [15:0] serial_frame_cfg_u1c0;
  reg [15:0] serial_frame_cfg_u1c1;

  // Data, baud and interrupt registers
  reg [8:0] tx_data;
  reg tx_pending;
  reg [8:0] rx_data;
  reg rx_full;
  reg [DIV_W-1:0] baud_div;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;

  wire [19:0] index = avs_address_i[ADDR_W-1:2];
  wire req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ~avs_waitrequest_o;
  wire rd_go = avs_read_i & ~avs_waitrequest_o;

  wire tx_busy;
  wire tx_done;
  wire tx_start;
  wire [8:0] rx_word;
  wire rx_done;
  wire rx_err;

  reg [31:0] next_readdata;
  reg [3:0] next_status;
  reg [3:0] irq_set;
  reg [3:0] irq_clr;

  // Merge a bus write into a configuration word: lanes, read-only bits, two-stop availability
  function [15:0] cfg_merge;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] be;
    input allow_two_stop;
    reg [15:0] lanes;
    begin
      lanes = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
      cfg_merge = (lanes & `SFC_CFG_WMASK) | `SFC_CFG_FIXED1;
      if (!allow_two_stop)
        cfg_merge = cfg_merge & `SFC_CFG_NO2STOP;
    end
  endfunction

  // Lane merge for plain data registers
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] wdata;
    input [1:0] be;
    begin
      lane_merge = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
    end
  endfunction

  // Wait state generator: one held cycle, then waitrequest low for exactly one cycle.
  // Writes land on the edge where the master sees waitrequest low, never earlier.
  always @(posedge clk_sys_i) begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else if (req && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  // Read data selection; unmapped addresses read as zero
  always @* begin
    next_readdata = 32'h00000000;
    case (index)
      `SFC_IDX_U0C0: next_readdata = {16'h0000, serial_frame_cfg_u0c0};
      `SFC_IDX_U0C3: next_readdata = {16'h0000, serial_frame_cfg_u0c3};
      `SFC_IDX_U1C0: next_readdata = {16'h0000, serial_frame_cfg_u1c0};
      `SFC_IDX_U1C1: next_readdata = {16'h0000, serial_frame_cfg_u1c1};
      `SFC_IDX_TXDATA: next_readdata = {23'h000000, tx_data};
      `SFC_IDX_RXDATA: next_readdata = {23'h000000, rx_data};
      `SFC_IDX_STATUS: next_readdata = {28'h0000000, irq_status};
      `SFC_IDX_MASK: next_readdata = {28'h0000000, irq_mask};
      `SFC_IDX_BAUD: next_readdata = {{(32-DIV_W){1'b0}}, baud_div};
      `SFC_IDX_STATE: next_readdata = {29'h00000000, rx_full, tx_pending, tx_busy};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Read data latched when the wait state ends and held for the answering cycle
  always @(posedge clk_sys_i) begin
    if (rst_i)
      avs_readdata_o <= 32'h00000000;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= next_readdata;
  end

  // Configuration registers; channels 00 and 10 keep the two-stop option
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      serial_frame_cfg_u0c0 <= `SFC_CFG_RESET;
      serial_frame_cfg_u0c3 <= `SFC_CFG_RESET;
      serial_frame_cfg_u1c0 <= `SFC_CFG_RESET;
      serial_frame_cfg_u1c1 <= `SFC_CFG_RESET;
    end else if (wr_go) begin
      case (index)
        `SFC_IDX_U0C0: serial_frame_cfg_u0c0 <=
          cfg_merge(serial_frame_cfg_u0c0, avs_writedata_i[15:0], avs_byteenable_i[1:0], 1'b1);
        `SFC_IDX_U0C3: serial_frame_cfg_u0c3 <=
          cfg_merge(serial_frame_cfg_u0c3, avs_writedata_i[15:0], avs_byteenable_i[1:0], 1'b0);
        `SFC_IDX_U1C0: serial_frame_cfg_u1c0 <=
          cfg_merge(serial_frame_cfg_u1c0, avs_writedata_i[15:0], avs_byteenable_i[1:0], 1'b1);
        `SFC_IDX_U1C1: serial_frame_cfg_u1c1 <=
          cfg_merge(serial_frame_cfg_u1c1, avs_writedata_i[15:0], avs_byteenable_i[1:0], 1'b0);
        default: ;
      endcase
    end
  end

  // Baud divisor and interrupt mask
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      baud_div <= `SFC_BAUD_RESET;
      irq_mask <= `SFC_MASK_RESET;
    end else if (wr_go) begin
      if (index == `SFC_IDX_BAUD)
        baud_div <= lane_merge(baud_div, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      if (index == `SFC_IDX_MASK && avs_byteenable_i[0])
        irq_mask <= avs_writedata_i[3:0];
    end
  end

  // Transmit holding word: a write queues one frame; a write while one is
  // queued replaces the queued word, it does not add a second frame.
  wire [15:0] tx_merged = lane_merge({7'h00, tx_data}, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_data <= 9'h000;
      tx_pending <= 1'b0;
    end else begin
      if (tx_start)
        tx_pending <= 1'b0;
      if (wr_go && index == `SFC_IDX_TXDATA) begin
        tx_data <= tx_merged[8:0];
        tx_pending <= 1'b1;
      end
    end
  end

  // Start only when idle and the transmit enable is set
  assign tx_start = tx_pending & ~tx_busy & serial_frame_cfg_u1c0[`SFC_TXE_BIT];

  // Receive buffer: a read of the data word frees it; a new word wins over that read
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_data <= 9'h000;
      rx_full <= 1'b0;
    end else begin
      if (rd_go && index == `SFC_IDX_RXDATA)
        rx_full <= 1'b0;
      if (rx_done) begin
        rx_data <= rx_word;
        rx_full <= 1'b1;
      end
    end
  end

  // Shared request flag sources
  always @* begin
    irq_set = 4'h0;
    irq_set[`SFC_IRQ_TXEND] = tx_done | u1c0_sync_irq_i | u1c0_twowire_irq_i;
    irq_set[`SFC_IRQ_RXEND] = rx_done | u1c1_sync_irq_i | u1c1_twowire_irq_i;
    // Error source only reaches the flag while its enable is set, so the timer may share it
    irq_set[`SFC_IRQ_RXERR] = (rx_err & serial_frame_cfg_u1c1[`SFC_EOC_BIT]) | timer_ch3_upper_irq_i;
    irq_set[`SFC_IRQ_OVR] = rx_done & rx_full & ~(rd_go && index == `SFC_IDX_RXDATA);
    irq_clr = 4'h0;
    if (wr_go && index == `SFC_IDX_STATUS && avs_byteenable_i[0])
      irq_clr = avs_writedata_i[3:0];
    // Set wins over a write-one-to-clear in the same cycle
    next_status = (irq_status & ~irq_clr) | irq_set;
  end

  // Sticky flags and the masked level output
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_status <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // Channel 10 transmits, channel 11 receives
  serial_frame_tx #(
    .DIV_W(DIV_W)
  ) u_tx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .div_i(baud_div),
    .start_i(tx_start),
    .data_i(tx_data),
    .parity_i(serial_frame_cfg_u1c0[`SFC_PAR_HI:`SFC_PAR_LO]),
    .lsb_first_i(serial_frame_cfg_u1c0[`SFC_DIR_BIT]),
    .stop_i(serial_frame_cfg_u1c0[`SFC_STOP_HI:`SFC_STOP_LO]),
    .len_i(serial_frame_cfg_u1c0[`SFC_LEN_HI:`SFC_LEN_LO]),
    .txd_o(txd_o),
    .busy_o(tx_busy),
    .done_o(tx_done)
  );

  serial_frame_rx #(
    .DIV_W(DIV_W)
  ) u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .div_i(baud_div),
    .enable_i(serial_frame_cfg_u1c1[`SFC_RXE_BIT]),
    .rxd_i(rxd_i),
    .parity_i(serial_frame_cfg_u1c1[`SFC_PAR_HI:`SFC_PAR_LO]),
    .lsb_first_i(serial_frame_cfg_u1c1[`SFC_DIR_BIT]),
    .stop_i(serial_frame_cfg_u1c1[`SFC_STOP_HI:`SFC_STOP_LO]),
    .len_i(serial_frame_cfg_u1c1[`SFC_LEN_HI:`SFC_LEN_LO]),
    .data_o(rx_word),
    .done_o(rx_done),
    .err_o(rx_err)
  );
endmodule // serial_frame_unit

// ==== bench/serial_frame_unit_properties.sv ====
// Bus, register and shared-flag properties of the serial frame unit
`timescale 1ns/100ps
`include "serial_frame_defs.vh"
module serial_frame_unit_props #(
  parameter ADDR_W = 22
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire u1c0_sync_irq_i,
  input wire u1c0_twowire_irq_i,
  input wire u1c1_sync_irq_i,
  input wire u1c1_twowire_irq_i,
  input wire timer_ch3_upper_irq_i,
  input wire irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Register decode
  wire [ADDR_W-3:0] idx = avs_address_i[ADDR_W-1:2];
  wire lock_hit = idx == `SFC_IDX_U0C3 || idx == `SFC_IDX_U1C1;
  wire cfg_hit = lock_hit || idx == `SFC_IDX_U0C0 || idx == `SFC_IDX_U1C0;
  wire own_hit = idx <= `SFC_IDX_STATE;
  wire take_rd = avs_read_i && avs_waitrequest_o;
  reg [3:0] mask;
  // Shadow of the unit's mask
  always @(posedge clk_sys_i) begin
    if (rst_i)
      mask <= `SFC_MASK_RESET;
    else if (avs_write_i && !avs_waitrequest_o && idx == `SFC_IDX_MASK && avs_byteenable_i[0])
      mask <= avs_writedata_i[3:0];
  end
  wait_one_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("wait low too long");
  wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered");
  wait_rest_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("wait low when idle");
  reserved_bits_a: assert property (take_rd && cfg_hit |=> avs_readdata_o[11] == 1'b0 &&
    avs_readdata_o[6] == 1'b0 && avs_readdata_o[3] == 1'b0 && avs_readdata_o[2] == 1'b1)
    else $error("reserved bits wrong");
  two_stop_lock_a: assert property (take_rd && lock_hit |=> avs_readdata_o[5] == 1'b0)
    else $error("two stop bits on locked channel");
  unmapped_zero_a: assert property (take_rd && !cfg_hit && !own_hit |=> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  flag0_share_a: assert property ((u1c0_sync_irq_i || u1c0_twowire_irq_i) && mask[0] |-> ##[1:3] irq_o)
    else $error("flag 0 missed irq");
  flag1_share_a: assert property ((u1c1_sync_irq_i || u1c1_twowire_irq_i) && mask[1] |-> ##[1:3] irq_o)
    else $error("flag 1 missed irq");
  flag2_share_a: assert property (timer_ch3_upper_irq_i && mask[2] |-> ##[1:3] irq_o)
    else $error("flag 2 missed irq");
  mask_quiet_a: assert property (mask == 4'h0 && $past(mask) == 4'h0 |-> !irq_o)
    else $error("irq while all masked");
endmodule // serial_frame_unit_props
bind serial_frame_unit serial_frame_unit_props #(.ADDR_W(ADDR_W)) i_props (.clk_sys_i, .rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .u1c0_sync_irq_i, .u1c0_twowire_irq_i, .u1c1_sync_irq_i, .u1c1_twowire_irq_i, .timer_ch3_upper_irq_i, .irq_o);

// ==== bench/serial_peer.sv ====
// Remote serial peer: captures and sends frames
`timescale 1ns/100ps
module serial_peer #(
  parameter int BAUD = 8
) (
  input wire logic clk_sys_i,
  input wire logic txd_i,
  output logic rxd_o
);
  int want_n = 1;
  int got_cnt = 0;
  logic [15:0] got = 16'hFFFF;
  // Line idles high between frames
  initial rxd_o = 1'b1;
  // Start bit, then the image from bit 0 up
  task automatic send(input logic [15:0] bits, input int n);
    rxd_o <= 1'b0;
    repeat (BAUD) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= bits[i];
      repeat (BAUD) @(posedge clk_sys_i);
    end
    rxd_o <= 1'b1;
  endtask
  // Mid-bit sampling; waits for idle so a low last bit is not a start
  always begin
    @(posedge clk_sys_i iff txd_i === 1'b0);
    got = 16'hFFFF;
    repeat (BAUD / 2) @(posedge clk_sys_i);
    for (int i = 0; i < want_n; i++) begin
      repeat (BAUD) @(posedge clk_sys_i);
      got[i] = txd_i;
    end
    got_cnt++;
    @(posedge clk_sys_i iff txd_i === 1'b1);
  end
endmodule // serial_peer

// ==== bench/serial_frame_unit_tb_top.sv ====
// Self-checking bench for the serial frame unit
`timescale 1ns/100ps
`include "serial_frame_defs.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module serial_frame_unit_tb_top;
  localparam int BAUD = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [21:0] address = '0;
  logic read_req = 1'b0;
  logic write_req = 1'b0;
  logic [31:0] wdata = '0;
  logic [4:0] src = '0;
  logic [31:0] rd;
  logic [15:0] tx_cfg [5] = '{16'h8013, 16'h81A2, 16'h8211, 16'h8383, 16'h82A3};
  logic [8:0] tx_dat [5] = '{9'h0A5, 9'h053, 9'h1C6, 9'h03B, 9'h081};
  wire [31:0] rdata;
  wire rxd, txd, irq, waitreq;
  int failures = 0;
  int check_count = 0;
  // Clock of 8 ns period
  always #4 clk_sys = ~clk_sys;
  serial_frame_unit i_dut (.clk_sys_i(clk_sys), .rst_i(rst), .avs_address_i(address), .avs_read_i(read_req),
    .avs_write_i(write_req), .avs_writedata_i(wdata), .avs_byteenable_i(4'h3), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .rxd_i(rxd), .txd_o(txd), .u1c0_sync_irq_i(src[0]), .u1c0_twowire_irq_i(src[1]),
    .u1c1_sync_irq_i(src[2]), .u1c1_twowire_irq_i(src[3]), .timer_ch3_upper_irq_i(src[4]), .irq_o(irq));
  serial_peer #(.BAUD(BAUD)) i_peer (.clk_sys_i(clk_sys), .txd_i(txd), .rxd_o(rxd));
  // Held until waitrequest is low, then one spare edge
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [15:0] d);
    int t;
    t = 0;
    address <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    write_req <= wr;
    read_req <= ~wr;
    do begin
      @(posedge clk_sys);
      t++;
    end while (waitreq !== 1'b0 && t < 50);
    rd = rdata;
    if (t >= 50) failures++;
    write_req <= 1'b0;
    read_req <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [19:0] idx, input logic [15:0] e, input string nm);
    bus(1'b0, idx, 16'h0000);
    `CHK(nm, e, rd[15:0])
  endtask
  // Wire image after the start bit; unused positions stay high
  function automatic int frame(input logic [8:0] d, input logic [15:0] cfg, output logic [15:0] v);
    int w;
    int n;
    logic p;
    w = (cfg[1:0] == `SFC_LEN_9) ? 9 : (cfg[1:0] == `SFC_LEN_7) ? 7 : 8;
    v = 16'hFFFF;
    p = 1'b0;
    for (n = 0; n < w; n++) begin
      v[n] = cfg[`SFC_DIR_BIT] ? d[n] : d[w-1-n];
      p ^= d[n];
    end
    if (cfg[9:8] != `SFC_PAR_NONE) begin
      v[n] = (cfg[9:8] == `SFC_PAR_EVEN) ? p : (cfg[9:8] == `SFC_PAR_ODD) ? ~p : 1'b0;
      n++;
    end
    return n + cfg[5:4];
  endfunction
  task automatic regs_case();
    logic [19:0] cfgs [4] = '{`SFC_IDX_U0C0, `SFC_IDX_U0C3, `SFC_IDX_U1C0, `SFC_IDX_U1C1};
    for (int i = 0; i < 4; i++) begin
      rd_chk(cfgs[i], 16'h0087, "cfg reset");
      bus(1'b1, cfgs[i], 16'hFFFF);
      rd_chk(cfgs[i], (i % 2 == 1) ? 16'hF797 : 16'hF7B7, "cfg ones");
      bus(1'b1, cfgs[i], 16'h0000);
      rd_chk(cfgs[i], 16'h0004, "cfg zeros");
    end
    rd_chk(`SFC_IDX_MASK, 16'h0000, "mask reset");
    rd_chk(`SFC_IDX_BAUD, 16'h043D, "baud reset");
    bus(1'b1, 20'h00040, 16'hFFFF);
    rd_chk(20'h00040, 16'h0000, "unmapped");
    bus(1'b1, `SFC_IDX_BAUD, 16'h0008);
    $display("regs test done");
  endtask
  // One-cycle source pulse
  task automatic pulse(input logic [4:0] s);
    src <= s;
    @(posedge clk_sys);
    src <= 5'h00;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic flag_case();
    logic [15:0] bmap [5] = '{16'h0001, 16'h0001, 16'h0002, 16'h0002, 16'h0004};
    bus(1'b1, `SFC_IDX_MASK, 16'h000F);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      `CHK("irq on source", 1'b1, irq)
      rd_chk(`SFC_IDX_STATUS, bmap[i], "status flag");
      bus(1'b1, `SFC_IDX_STATUS, bmap[i]);
      rd_chk(`SFC_IDX_STATUS, 16'h0000, "status cleared");
    end
    bus(1'b1, `SFC_IDX_MASK, 16'h000E);
    pulse(5'h02);
    `CHK("irq masked", 1'b0, irq)
    rd_chk(`SFC_IDX_STATUS, 16'h0001, "masked flag");
    bus(1'b1, `SFC_IDX_MASK, 16'h000F);
    repeat (2) @(posedge clk_sys);
    `CHK("irq unmasked", 1'b1, irq)
    bus(1'b1, `SFC_IDX_STATUS, 16'h000F);
    $display("flag test done");
  endtask
  task automatic tx_case(input logic [15:0] cfg, input logic [8:0] d);
    logic [15:0] v;
    int c;
    int t;
    i_peer.want_n = frame(d, cfg, v);
    c = i_peer.got_cnt;
    bus(1'b1, `SFC_IDX_U1C0, cfg);
    bus(1'b1, `SFC_IDX_MASK, 16'h0001);
    bus(1'b1, `SFC_IDX_TXDATA, {7'h00, d});
    for (t = 0; t < 400 && i_peer.got_cnt == c; t++) @(posedge clk_sys);
    if (t >= 400) failures++;
    `CHK("tx frame", v, i_peer.got)
    `CHK("irq in last bit", 1'b0, irq)
    for (t = 0; t < 3 * BAUD && irq !== 1'b1; t++) @(posedge clk_sys);
    `CHK("irq after frame", 1'b1, irq)
    bus(1'b1, `SFC_IDX_STATUS, 16'h000F);
    $display("tx test %h done", cfg);
  endtask
  task automatic rx_case(input logic [15:0] cfg, input logic [8:0] d, input logic bad);
    logic [15:0] v;
    int n;
    int t;
    n = frame(d, cfg, v);
    v[n-2] ^= bad;
    bus(1'b1, `SFC_IDX_U1C1, cfg);
    i_peer.send(v, n);
    t = 0;
    do begin
      bus(1'b0, `SFC_IDX_STATUS, 16'h0000);
      t++;
    end while (rd[1] !== 1'b1 && t < 20);
    `CHK("rx end flag", 1'b1, rd[1])
    `CHK("rx error flag", bad & cfg[`SFC_EOC_BIT], rd[2])
    rd_chk(`SFC_IDX_RXDATA, {7'h00, d} & ((cfg[1:0] == `SFC_LEN_7) ? 16'h007F : 16'h00FF), "rx data");
    bus(1'b1, `SFC_IDX_STATUS, 16'h000F);
    $display("rx test %h done", cfg);
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence; UART frames only receive configs keep one stop bit
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    regs_case();
    flag_case();
    for (int i = 0; i < 5; i++) tx_case(tx_cfg[i], tx_dat[i]);
    rx_case(16'h4692, 9'h035, 1'b0);
    rx_case(16'h4713, 9'h0C4, 1'b1);
    rx_case(16'h4313, 9'h0C4, 1'b1);
    close_out();
  end
  // Watchdog, far past a run of about a thousand cycles
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule // serial_frame_unit_tb_top
